// ### design/uwake_defs.vh
// Purpose: constants for the wake-on-edge and baud divider block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: all offsets are byte addresses
// What this block does
// - 8-bit mode without high speed: baud equals clock over 64(divisor+1)
// - wake mode senses rising edges on receive line
// - wake enable puts receiver idle awaiting wake
// - wake event sets receive pending flag
// - next rising edge clears wake enable by hardware
// - reading receive holding register clears wake condition
// - baud control bit 2 reads as zero
`ifndef UWAKE_DEFS_VH
`define UWAKE_DEFS_VH
// ===================================================
// register offsets
`define UW_OFF_TXSC 8'h00
`define UW_OFF_RXSC 8'h04
`define UW_OFF_BAUDCTL 8'h08
`define UW_OFF_DIVHI 8'h0C
`define UW_OFF_DIVLO 8'h10
`define UW_OFF_HOLD 8'h14
`define UW_OFF_IRQSTAT 8'h18
`define UW_OFF_IRQEN 8'h1C
`define UW_OFF_IRQCLR 8'h20
// ===================================================
// baud control fields
`define UW_BC_OVF 7
`define UW_BC_IDLE 6
`define UW_BC_RXPOL 5
`define UW_BC_TXPOL 4
`define UW_BC_WIDE 3
`define UW_BC_WAKE 1
`define UW_BC_AUTOBAUD 0
`define UW_BC_WMASK 8'h3B
// transmit status control: high speed select
`define UW_TX_HS 2
// ===================================================
// reset values
`define UW_RST_TXSC 8'h02
`define UW_RST_RXSC 8'h00
`define UW_RST_BAUDCTL 8'h40
`define UW_RST_DIV 8'h00
// ===================================================
// timing: 8-bit async mode without high speed prescale is 64 clocks per divisor step
`define UW_PRE_SLOW 7'h3F
`define UW_PRE_FAST 7'h0F
`define UW_PRE_WIDE 7'h03
// interrupt status bits
`define UW_IRQ_WAKE 0
`define UW_IRQ_RX 1
`endif

// ### design/uwake_baud_divider.v
// Purpose: baud tick generator from a 16-bit divisor
// Assumes: divisor and mode stable or changed between ticks
// Notes: tick is a one-cycle enable pulse on core_clk
`include "uwake_defs.vh"
module uwake_baud_divider (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // configuration
  input wire [7:0] divisorHigh,
  input wire [7:0] divisorLow,
  input wire wideSelect,
  input wire highSpeed,
  // output
  output reg baudTick
);
  reg [6:0] preCount;
  reg [15:0] divCount;
  wire [6:0] preTop;
  wire [15:0] divTop;
  wire preDone;

  assign preTop = wideSelect ? (highSpeed ? 7'h00 : `UW_PRE_WIDE) :
                  (highSpeed ? `UW_PRE_FAST : `UW_PRE_SLOW);
  // narrow mode uses only the low byte; the high byte has no effect
  assign divTop = wideSelect ? {divisorHigh, divisorLow} : {8'h00, divisorLow};
  assign preDone = (preCount >= preTop);

  // ===================================================
  // two stage count: prescaler then divisor, giving clk/(64(n+1)) in slow narrow mode (16, 4 or 1 per step otherwise)
  always @(posedge core_clk) begin
    if (reset) begin
      preCount <= 7'h00;
      divCount <= 16'h0000;
      baudTick <= 1'b0;
    end else begin
      baudTick <= 1'b0;
      if (preDone) begin
        preCount <= 7'h00;
        if (divCount >= divTop) begin
          divCount <= 16'h0000;
          baudTick <= 1'b1;
        end else begin
          divCount <= divCount + 16'h0001;
        end
      end else begin
        preCount <= preCount + 7'h01;
      end
    end
  end
endmodule

// ### design/uwake_top.v
// Purpose: wake-on-edge receive idle logic with baud divider and registers
// Assumes: receive line synchronous to core_clk; AXI4-Lite master
// Notes: no serial shifter here; receive data arrives on a byte port
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`include "uwake_defs.vh"
module uwake_top (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // serial side
  input wire receiveLine,
  input wire [7:0] rxByte,
  input wire rxByteValid,
  input wire rxBusy,
  // outputs
  output reg baudTick,
  output reg irq
);
  reg [7:0] txStatus;
  reg [7:0] rxStatus;
  reg [7:0] baudCtl;
  reg [7:0] divHigh;
  reg [7:0] divLow;
  reg [7:0] holdReg;
  reg receivePending;
  reg wakePending;
  reg [1:0] irqStatus;
  reg [1:0] irqEnable;
  reg lineD;
  reg [1:0] wakeState;
  reg awHeld;
  reg [7:0] awAddr;
  reg wHeld;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire dividerTick;
  wire lineLevel;
  wire riseEdge;
  wire doWrite;
  wire doRead;
  wire wakeEvent;
  wire wakeDone;
  wire holdRead;
  wire [7:0] wByte;
  wire [7:0] baudView;
  wire regWrite;
  wire hitTxsc;
  wire hitRxsc;
  wire hitBaud;
  wire hitDivHi;
  wire hitDivLo;
  wire hitIrqEn;
  wire hitIrqClr;
  wire clearWake;
  wire clearRx;
  wire writeErr;
  wire [5:0] readIndex;

  localparam WK_OFF = 2'b00;
  localparam WK_ARMED = 2'b01;
  localparam WK_WOKEN = 2'b10;

  // ===================================================
  // register write helper
  function wordHit;
    input [7:0] addr;
    input [7:0] off;
    begin
      wordHit = (addr[7:2] == off[7:2]);
    end
  endfunction

  // ===================================================
  // baud divider
  uwake_baud_divider uwake_baud_divider_inst (
    .core_clk(core_clk),
    .reset(reset),
    .divisorHigh(divHigh),
    .divisorLow(divLow),
    .wideSelect(baudCtl[`UW_BC_WIDE]),
    .highSpeed(txStatus[`UW_TX_HS]),
    .baudTick(dividerTick)
  );

  always @(posedge core_clk) begin
    if (reset) begin
      baudTick <= 1'b0;
    end else begin
      baudTick <= dividerTick;
    end
  end

  // ===================================================
  // receive line edge sensing, polarity applied first
  assign lineLevel = receiveLine ^ baudCtl[`UW_BC_RXPOL];
  assign riseEdge = lineLevel & ~lineD;

  always @(posedge core_clk) begin
    if (reset) begin
      lineD <= 1'b1;
    end else begin
      lineD <= lineLevel;
    end
  end

  // ===================================================
  // axi4-lite slave, one write and one read at a time
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  assign doRead = s_axi_arvalid & s_axi_arready;
  assign wByte = wStrb[0] ? wData[7:0] : 8'h00;
  assign holdRead = doRead & wordHit(s_axi_araddr, `UW_OFF_HOLD);

  always @(posedge core_clk) begin
    if (reset) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeErr ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ===================================================
  // write decode, one hit per register word
  assign regWrite = doWrite & wStrb[0];
  assign hitTxsc = wordHit(awAddr, `UW_OFF_TXSC);
  assign hitRxsc = wordHit(awAddr, `UW_OFF_RXSC);
  assign hitBaud = wordHit(awAddr, `UW_OFF_BAUDCTL);
  assign hitDivHi = wordHit(awAddr, `UW_OFF_DIVHI);
  assign hitDivLo = wordHit(awAddr, `UW_OFF_DIVLO);
  assign hitIrqEn = wordHit(awAddr, `UW_OFF_IRQEN);
  assign hitIrqClr = wordHit(awAddr, `UW_OFF_IRQCLR);
  // writes above offset 0x20 are refused with an error; those at 0x21 to 0x23 still reach the interrupt clear register
  assign writeErr = (awAddr > `UW_OFF_IRQCLR);

  // ===================================================
  // wake sequencer
  // idle on arm, flag on first edge, self-clear on the following edge
  assign wakeEvent = (wakeState == WK_ARMED) & riseEdge;
  assign wakeDone = (wakeState == WK_WOKEN) & riseEdge;

  always @(posedge core_clk) begin
    if (reset) begin
      wakeState <= WK_OFF;
    end else begin
      case (wakeState)
        WK_OFF: begin
          if (baudCtl[`UW_BC_WAKE]) begin
            wakeState <= WK_ARMED;
          end
        end
        WK_ARMED: begin
          if (!baudCtl[`UW_BC_WAKE]) begin
            wakeState <= WK_OFF;
          end else if (riseEdge) begin
            wakeState <= WK_WOKEN;
          end
        end
        WK_WOKEN: begin
          if (riseEdge | ~baudCtl[`UW_BC_WAKE]) begin
            wakeState <= WK_OFF;
          end
        end
        default: begin
          wakeState <= WK_OFF;
        end
      endcase
    end
  end

  // ===================================================
  // control registers
  always @(posedge core_clk) begin
    if (reset) begin
      txStatus <= `UW_RST_TXSC;
      rxStatus <= `UW_RST_RXSC;
      divHigh <= `UW_RST_DIV;
      divLow <= `UW_RST_DIV;
      irqEnable <= 2'b00;
    end else begin
      if (regWrite & hitTxsc) begin
        txStatus <= wByte;
      end
      if (regWrite & hitRxsc) begin
        rxStatus <= wByte;
      end
      if (regWrite & hitDivHi) begin
        divHigh <= wByte;
      end
      if (regWrite & hitDivLo) begin
        divLow <= wByte;
      end
      if (regWrite & hitIrqEn) begin
        irqEnable <= wByte[1:0];
      end
    end
  end

  // ===================================================
  // baud control: idle status follows the receiver, wake bit self-clears
  always @(posedge core_clk) begin
    if (reset) begin
      baudCtl <= `UW_RST_BAUDCTL;
    end else begin
      // idle status tracks the receiver; arming while busy would lose a byte
      baudCtl[`UW_BC_IDLE] <= ~rxBusy;
      if (regWrite & hitBaud) begin
        baudCtl[`UW_BC_OVF] <= wByte[`UW_BC_OVF];
        baudCtl[`UW_BC_RXPOL] <= wByte[`UW_BC_RXPOL];
        baudCtl[`UW_BC_TXPOL] <= wByte[`UW_BC_TXPOL];
        baudCtl[`UW_BC_WIDE] <= wByte[`UW_BC_WIDE];
        baudCtl[`UW_BC_WAKE] <= wakeDone ? 1'b0 : wByte[`UW_BC_WAKE];
        baudCtl[`UW_BC_AUTOBAUD] <= wByte[`UW_BC_AUTOBAUD];
      end else if (wakeDone) begin
        baudCtl[`UW_BC_WAKE] <= 1'b0;
      end
      baudCtl[2] <= 1'b0;
    end
  end

  // ===================================================
  // receive holding register and pending flag
  // a wake yields a zero dummy character for software to drop
  always @(posedge core_clk) begin
    if (reset) begin
      holdReg <= 8'h00;
      receivePending <= 1'b0;
      wakePending <= 1'b0;
    end else begin
      if (wakeEvent) begin
        holdReg <= 8'h00;
      end else if (rxByteValid & (wakeState == WK_OFF)) begin
        holdReg <= rxByte;
      end
      // set wins over the clearing read
      if (wakeEvent | (rxByteValid & (wakeState == WK_OFF))) begin
        receivePending <= 1'b1;
      end else if (holdRead) begin
        receivePending <= 1'b0;
      end
      if (wakeEvent) begin
        wakePending <= 1'b1;
      end else if (holdRead) begin
        wakePending <= 1'b0;
      end
    end
  end

  // ===================================================
  // sticky interrupt status, clear by writing ones; a set in the same cycle wins
  assign clearWake = regWrite & hitIrqClr & wByte[`UW_IRQ_WAKE];
  assign clearRx = regWrite & hitIrqClr & wByte[`UW_IRQ_RX];

  always @(posedge core_clk) begin
    if (reset) begin
      irqStatus <= 2'b00;
      irq <= 1'b0;
    end else begin
      irqStatus[`UW_IRQ_WAKE] <= wakeEvent | (irqStatus[`UW_IRQ_WAKE] & ~clearWake);
      irqStatus[`UW_IRQ_RX] <= receivePending | (irqStatus[`UW_IRQ_RX] & ~clearRx);
      irq <= |(irqStatus & irqEnable);
    end
  end

  // ===================================================
  // read path
  assign baudView = {baudCtl[7:3], 1'b0, baudCtl[1:0]};
  assign readIndex = s_axi_araddr[7:2];

  always @(posedge core_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (readIndex)
        6'h00: s_axi_rdata <= {24'h000000, txStatus};
        6'h01: s_axi_rdata <= {24'h000000, rxStatus};
        6'h02: s_axi_rdata <= {24'h000000, baudView};
        6'h03: s_axi_rdata <= {24'h000000, divHigh};
        6'h04: s_axi_rdata <= {24'h000000, divLow};
        6'h05: begin
          // the read that returns this byte also drops the pending flag
          s_axi_rdata <= {24'h000000, holdReg};
        end
        6'h06: s_axi_rdata <= {29'h00000000, wakePending, irqStatus};
        6'h07: s_axi_rdata <= {30'h00000000, irqEnable};
        6'h08: s_axi_rdata <= 32'h00000000;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### tb/uwake_assertions.sv
// Purpose: timing and wake checks on the top ports of the block
// Assumes: one write and one read in flight at a time
// Notes: shadow registers update at the write response handshake
module uwake_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // serial side and outputs
  input wire logic receiveLine,
  input wire logic rxByteValid,
  input wire logic baudTick,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] awQ, wQ, arQ, txsc, bc, divLo, irqEn;
  logic [1:0] mode;
  logic prevLine, pend, tickSeen;
  logic [15:0] cnt;
  wire lineNow = receiveLine ^ bc[5];
  wire edgeUp = lineNow & ~prevLine;
  wire slow8 = !txsc[2] && !bc[3];
  wire wrDone = s_axi_bvalid && s_axi_bready;
  // ======
  // shadows; a write voids the period count since the divisor may change
  always @(posedge core_clk) begin
    if (reset) begin
      txsc <= 8'h02;
      bc <= 8'h40;
      divLo <= 8'h00;
      irqEn <= 8'h00;
      mode <= 2'h0;
      prevLine <= 1'b1;
      pend <= 1'b0;
      tickSeen <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      prevLine <= lineNow;
      cnt <= baudTick ? 16'h0000 : cnt + 16'h0001;
      tickSeen <= !wrDone && (baudTick || tickSeen);
      if (s_axi_awvalid && s_axi_awready) awQ <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wQ <= s_axi_wdata[7:0];
      if (s_axi_arvalid && s_axi_arready) arQ <= s_axi_araddr;
      if (edgeUp && mode != 2'h0) mode <= (mode == 2'h1) ? 2'h2 : 2'h0;
      if (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14) pend <= 1'b0;
      if (edgeUp && mode == 2'h1) pend <= 1'b1;
      if (wrDone && awQ == 8'h00) txsc <= wQ;
      if (wrDone && awQ == 8'h08) bc <= wQ;
      if (wrDone && awQ == 8'h08) mode <= {1'b0, wQ[1]};
      if (wrDone && awQ == 8'h10) divLo <= wQ;
      if (wrDone && awQ == 8'h1C) irqEn <= wQ;
    end
  end
  // ======
  // properties
  property p_tick_period;
    @(posedge core_clk) disable iff (reset)
    baudTick && tickSeen && slow8 |->
      cnt == ({8'h00, divLo} + 16'h0001) * 16'h0040 - 16'h0001;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("baud tick period wrong");
  property p_bit2_zero;
    @(posedge core_clk) disable iff (reset)
    $rose(s_axi_rvalid) && arQ == 8'h08 |-> s_axi_rdata[2] == 1'b0;
  endproperty
  a_bit2_zero: assert property (p_bit2_zero)
    else $error("baud control bit 2 not zero");
  property p_wake_bit;
    @(posedge core_clk) disable iff (reset)
    $rose(s_axi_rvalid) && arQ == 8'h08 |-> s_axi_rdata[1] == (mode != 2'h0);
  endproperty
  a_wake_bit: assert property (p_wake_bit)
    else $error("wake enable bit wrong");
  property p_pend;
    @(posedge core_clk) disable iff (reset)
    $rose(s_axi_rvalid) && arQ == 8'h18 |-> s_axi_rdata[2] == pend;
  endproperty
  a_pend: assert property (p_pend)
    else $error("wake pending status wrong");
  property p_wake_irq;
    @(posedge core_clk) disable iff (reset)
    edgeUp && mode == 2'h1 && irqEn[1:0] != 2'h0 |-> ##[1:4] irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("no interrupt after wake edge");
  property p_armed_quiet;
    @(posedge core_clk) disable iff (reset)
    mode == 2'h1 && rxByteValid && !irq |=> !irq [*3];
  endproperty
  a_armed_quiet: assert property (p_armed_quiet)
    else $error("byte taken while armed");
  property p_fall_ignored;
    @(posedge core_clk) disable iff (reset)
    mode == 2'h1 && prevLine && !lineNow && !irq |=> !irq [*3];
  endproperty
  a_fall_ignored: assert property (p_fall_ignored)
    else $error("falling edge woke receiver");
  property p_irq_en;
    @(posedge core_clk) disable iff (reset)
    $rose(irq) |-> irqEn != 8'h00;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt with no enable");
endmodule
bind uwake_top uwake_assertions uwake_assertions_inst (.core_clk(core_clk), .reset(reset),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .receiveLine(receiveLine), .rxByteValid(rxByteValid),
  .baudTick(baudTick), .irq(irq));

// ### tb/uwake_remote_node.sv
// Purpose: remote serial node on the receive side
// Assumes: line idles high, one character at a time
// Notes: byte port stands in for the external shifter
module uwake_remote_node #(parameter int BIT_CLKS = 8) (
  // clock
  input wire logic core_clk,
  // serial side
  output logic receiveLine,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic rxBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    receiveLine = 1'b1;
    rxByte = 8'hA5;
    rxByteValid = 1'b0;
    rxBusy = 1'b0;
  end
  // all-zero character: start bit and eight zero bits before the stop edge
  task automatic start_char;
    @(posedge core_clk);
    rxBusy <= 1'b1;
    receiveLine <= 1'b0;
    repeat (9 * BIT_CLKS) @(posedge core_clk);
  endtask
  // idle after the stop edge gives the far end time to start up
  task automatic end_char(input int idleBits);
    receiveLine <= 1'b1;
    repeat (idleBits * BIT_CLKS) @(posedge core_clk);
    rxBusy <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(posedge core_clk);
    rxByte <= b;
    rxByteValid <= 1'b1;
    @(posedge core_clk);
    rxByte <= ~b;
    rxByteValid <= 1'b0;
  endtask
endmodule

// ### tb/test_uart_wakeup_and_baud_divider.sv
// Purpose: directed bench for wake-on-edge and baud divider
// Assumes: remote node model drives the serial side
// Notes: registers reached only through the bus task
module test_uart_wakeup_and_baud_divider;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00, rd;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h00000000;
  logic [1:0] rsp;
  wire awReady, wReady, bValid, arReady, rValid, receiveLine, rxByteValid, rxBusy;
  wire baudTick, irq;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [7:0] rxByte;
  int failures = 0, comparisons = 0, n, i;
  uwake_top uwake_top_inst (.core_clk(core_clk), .reset(reset), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .receiveLine(receiveLine), .rxByte(rxByte), .rxByteValid(rxByteValid), .rxBusy(rxBusy),
    .baudTick(baudTick), .irq(irq));
  uwake_remote_node uwake_remote_node_inst (.core_clk(core_clk), .receiveLine(receiveLine),
    .rxByte(rxByte), .rxByteValid(rxByteValid), .rxBusy(rxBusy));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // ======
  // tasks
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write and read share one sequence; each channel drops valid once taken
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    awAddr <= a;
    arAddr <= a;
    wData <= {24'h000000, d};
    awValid <= wr;
    wValid <= wr;
    bReady <= wr;
    arValid <= !wr;
    rReady <= !wr;
    do begin
      @(posedge core_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (arReady) arValid <= 1'b0;
      k++;
    end while (!(wr ? bValid : rValid) && k < 100);
    rsp = wr ? bResp : rResp;
    rd = rData[7:0];
    bReady <= 1'b0;
    rReady <= 1'b0;
    if (!(wr ? bValid : rValid)) begin
      failures++;
      final_report;
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    check(what, {8'h00, exp}, {8'h00, rd});
  endtask
  task automatic wait_tick;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!baudTick && n < 2000);
    if (!baudTick) begin
      failures++;
      final_report;
    end
  endtask
  // first tick after a change is not measured; the next full period is
  task automatic period_chk(input logic [15:0] exp, input string what);
    wait_tick;
    wait_tick;
    check(what, exp, n[15:0]);
  endtask
  // ======
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rdchk(8'h00, 8'h02, "txsc");
    rdchk(8'h04, 8'h00, "rxsc");
    rdchk(8'h08, 8'h40, "baudctl");
    rdchk(8'h0C, 8'h00, "divhi");
    rdchk(8'h10, 8'h00, "divlo");
    bus(1'b0, 8'h24, 8'h00);
    check("rresp", 16'h0002, {14'h0000, rsp});
    bus(1'b1, 8'h24, 8'h00);
    check("bresp", 16'h0002, {14'h0000, rsp});
    bus(1'b1, 8'h08, 8'h04);
    rdchk(8'h08, 8'h40, "bit2");
    // slow 8-bit mode; high byte set so a wide count would show
    bus(1'b1, 8'h00, 8'h00);
    bus(1'b1, 8'h0C, 8'hFF);
    bus(1'b1, 8'h10, 8'h03);
    for (i = 0; i < 3; i++)
      wait_tick;
    check("period", 16'h0040 * 16'h0004, n[15:0]);
    // other divider modes: wide 4 clocks, wide fast 1, narrow fast 16 per step
    bus(1'b1, 8'h0C, 8'h01);
    bus(1'b1, 8'h08, 8'h08);
    period_chk(16'h0410, "wide period");
    bus(1'b1, 8'h00, 8'h04);
    period_chk(16'h0104, "wide fast period");
    bus(1'b1, 8'h08, 8'h00);
    period_chk(16'h0040, "fast period");
    bus(1'b1, 8'h00, 8'h00);
    period_chk(16'h0100, "slow period");
    bus(1'b1, 8'h1C, 8'h03);
    rdchk(8'h08, 8'h40, "idle before arm");
    bus(1'b1, 8'h08, 8'h02);
    rdchk(8'h08, 8'h42, "armed");
    uwake_remote_node_inst.send_byte(8'h55);
    repeat (5) @(posedge core_clk);
    check("irq armed", 16'h0000, {15'h0000, irq});
    uwake_remote_node_inst.start_char;
    check("irq fall", 16'h0000, {15'h0000, irq});
    rdchk(8'h08, 8'h02, "busy");
    uwake_remote_node_inst.end_char(10);
    check("irq wake", 16'h0001, {15'h0000, irq});
    rdchk(8'h18, 8'h07, "status");
    rdchk(8'h14, 8'h00, "dummy");
    rdchk(8'h18, 8'h03, "status read");
    rdchk(8'h08, 8'h42, "wake held");
    uwake_remote_node_inst.start_char;
    uwake_remote_node_inst.end_char(10);
    rdchk(8'h08, 8'h40, "wake off");
    bus(1'b1, 8'h20, 8'h07);
    repeat (3) @(posedge core_clk);
    check("irq clear", 16'h0000, {15'h0000, irq});
    final_report;
  end
endmodule
